// ### inc/adc_ctrl_defs.svh
// Constants for the second converter control register and its result FIFO.
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// Bit positions of the second control register.
`define CR1_RESET_BIT      0
`define CR1_FIFO_BIT       1
`define CR1_THR_LO_BIT     2
`define CR1_THR_HI_BIT     3
`define CR1_PULSE_BIT      4
`define CR1_POL_BIT        5
`define CR1_RW_BIT         6
`define CR1_CODING_BIT     7
`define CR1_CAL_BIT        8
`define CR1_ECHO_BIT       9
// Data pin 10 selects which control register a write goes to.
`define REG_SEL_BIT        10

// Reset value of the stored fields, bits 9 down to 2.
`define CR1_CFG_RESET      8'h0c

// Result FIFO geometry, control register and data bus widths.
`define FIFO_DEPTH         16
`define FIFO_PTR_W         4
`define FIFO_CNT_W         5
`define RESULT_W           12
`define CR_W               10
`define DBUS_W             11

// Conversion clock edges after a software reset before the first result.
`define SETTLE_CYCLES      3'h5

// Midscale code, used to turn the calibration result into a signed error.
`define MIDSCALE           12'h800

`endif

// ### inc/adc_ctrl_pkg.sv
// Types shared by the converter control register block.
`default_nettype none
package adc_ctrl_pkg;

   // Stored fields of the second control register, bit 9 down to bit 2.
   typedef struct packed {
      logic       echo;
      logic       cal;
      logic       coding;
      logic       rw_comb;
      logic       pol;
      logic       pulse;
      logic [1:0] thr;
   } cfg_s;

   // Host pins and timing clocks as they arrive from outside the clock domain.
   typedef struct packed {
      logic        cs0_n;
      logic        cs1;
      logic        rd_n;
      logic        wr_n;
      logic        conversion_clock;
      logic        osc_clock;
      logic [10:0] data;
   } pins_s;

   // A converted result on its way to the FIFO.
   typedef struct packed {
      logic        valid;
      logic [11:0] value;
   } result_s;

endpackage
`default_nettype wire

// ### logic/sync2.sv
// Two flip-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             reset_n,
   // Pins in, synchronised copy out.
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_state_s;

   sync_state_s st_r;
   sync_state_s st_nxt;

   // Only the second stage reads the first one.
   always_comb begin
      st_nxt        = st_r;
      st_nxt.first  = async_in;
      st_nxt.second = st_r.first;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.second;

endmodule
`default_nettype wire

// ### logic/result_format.sv
// Offset correction and output coding of one conversion result.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_defs.svh"
module result_format
   import adc_ctrl_pkg::*;
(
   // Clock and reset.
   input  wire logic          clock,
   input  wire logic          reset_n,
   // Raw straight-binary result and its correction.
   input  wire logic          raw_valid,
   input  wire logic [11:0]   raw_value,
   input  wire logic [11:0]   offset_err,
   input  wire logic          coding_bin,
   // Corrected result.
   output result_s            result
);

   result_s         st_r;
   result_s         st_nxt;
   logic signed [13:0] diff;

   // The error is signed, so the subtraction is clamped rather than allowed to wrap.
   always_comb begin
      st_nxt       = st_r;
      diff         = $signed({2'b00, raw_value}) - $signed({{2{offset_err[11]}}, offset_err});
      st_nxt.valid = raw_valid;
      if (raw_valid) begin
         if (diff < 0) begin
            st_nxt.value = 12'h000;
         end else if (diff > 14'sh0fff) begin
            st_nxt.value = 12'hfff;
         end else begin
            st_nxt.value = diff[11:0];                             // [RQ17]
         end
         if (!coding_bin) begin
            st_nxt.value[11] = ~st_nxt.value[11];                   // [RQ15]
         end
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign result = st_r;

endmodule
`default_nettype wire

// ### logic/adc_fifo_control_register.sv
// Second converter control register with result FIFO, strobe decode and samples-ready.
`timescale 1ns/1ns
`default_nettype none
`include "adc_ctrl_defs.svh"
// Behaviour
// RQ1: Reset bit restores registers, FIFO, offset.
// RQ2: First result five clocks after reset.
// RQ3: Bit 1 reads back FIFO overflow.
// RQ4: Overflow flag clears after register read.
// RQ5: Writing bit 1 clears the FIFO.
// RQ6: Bits 3:2 pick threshold for samples-ready.
// RQ7: Threshold depends on scanned channel count.
// RQ8: One channel: 1, 4, 8, 14.
// RQ9: Two channels: 2, 4, 8, 12.
// RQ10: Three: 3,6,9,12; four: 4,8,12.
// RQ11: Bit 4 selects level or pulse.
// RQ12: Bit 5 selects polarity, resets high.
// RQ13: Bit 6 set: write pin is direction.
// RQ14: Bit 6 clear: separate read, write pins.
// RQ15: Bit 7 selects two's complement or binary.
// RQ16: Bit 8 calibrates offset from zeroed inputs.
// RQ17: Stored offset subtracted from later results.
// RQ18: Bit 9: reads echo register 0, 1.
// RQ19: Host reinitialises to leave echo mode.
// RQ20: Level clears on first read, rearms later.
// RQ21: Pulse half clock, next after batch read.
// RQ22: Reset bit wins over other written bits.
// RQ23: Host avoids reserved four-channel threshold code.
module adc_fifo_control_register
   import adc_ctrl_pkg::*;
(
   // Clock and reset.
   input  wire logic          clock,
   input  wire logic          reset_n,
   // Host bus pins, asynchronous.
   input  wire logic          cs0_n,
   input  wire logic          cs1,
   input  wire logic          rd_n,
   input  wire logic          wr_n,
   input  wire logic [10:0]   data_in,
   output logic      [11:0]   data_out,
   output logic               data_oe,
   output logic               samples_ready_out,
   // Timing clocks, asynchronous.
   input  wire logic          conversion_clock,
   input  wire logic          osc_clock,
   // Converter core, same clock.
   input  wire logic          single_conv_mode,
   input  wire logic [1:0]    scan_channels,
   input  wire logic          sample_valid,
   input  wire logic [11:0]   sample_raw,
   output logic               force_zero_inputs,
   // First control register, kept elsewhere.
   input  wire logic [9:0]    ctrl0_value,
   output logic               ctrl0_write,
   output logic      [9:0]    ctrl0_data,
   output logic               soft_reset_out
);

   typedef struct packed {
      cfg_s                                      cfg;
      logic                                      ovf;
      logic [`FIFO_DEPTH-1:0][`RESULT_W-1:0]     mem;
      logic [`FIFO_PTR_W-1:0]                    wptr;
      logic [`FIFO_PTR_W-1:0]                    rptr;
      logic [`FIFO_CNT_W-1:0]                    count;
      logic                                      prev_rd;
      logic                                      prev_wr;
      logic                                      prev_tclk;
      logic                                      prev_cclk;
      logic                                      active;
      logic                                      armed;
      logic [`FIFO_CNT_W-1:0]                    reads_left;
      logic [2:0]                                settle;
      logic [`RESULT_W-1:0]                      offset;
      logic                                      echo_second;
      logic [`RESULT_W-1:0]                      dout;
      logic                                      doe;
      logic                                      rdy_out;
      logic                                      soft_rst;
      logic                                      reg0_wr;
      logic [`CR_W-1:0]                          reg0_data;
   } ctrl_state_s;

   ctrl_state_s st_r;
   ctrl_state_s st_nxt;
   pins_s       pins_async;
   pins_s       pins;
   result_s     result;
   logic        cs_act;
   logic        rd_act;
   logic        wr_act;
   logic        rd_start;
   logic        wr_end;
   logic        tclk_sel;
   logic        cclk_rise;
   logic        raw_ok;
   logic        push;
   logic        pop;
   logic [`FIFO_CNT_W-1:0] thr_count;

   // Threshold in stored results for a code and a channel count (0 means one channel).
   function automatic logic [`FIFO_CNT_W-1:0] threshold_count(input logic [1:0] code,
                                                              input logic [1:0] nch);
      logic [`FIFO_CNT_W-1:0] t;
      t = 5'h0c;
      case (nch)                                                     // [RQ7]
         2'h0: case (code)                                           // [RQ8]
            2'h0:    t = 5'h01;
            2'h1:    t = 5'h04;
            2'h2:    t = 5'h08;
            default: t = 5'h0e;
         endcase
         2'h1: case (code)                                           // [RQ9]
            2'h0:    t = 5'h02;
            2'h1:    t = 5'h04;
            2'h2:    t = 5'h08;
            default: t = 5'h0c;
         endcase
         2'h2: case (code)                                           // [RQ10]
            2'h0:    t = 5'h03;
            2'h1:    t = 5'h06;
            2'h2:    t = 5'h09;
            default: t = 5'h0c;
         endcase
         default: case (code)                                        // [RQ10]
            2'h0:    t = 5'h04;
            2'h1:    t = 5'h08;
            // The reserved code behaves as the largest legal level.
            default: t = 5'h0c;                                      // [RQ23]
         endcase
      endcase
      return t;
   endfunction

   assign pins_async = '{cs0_n: cs0_n, cs1: cs1, rd_n: rd_n, wr_n: wr_n,
                         conversion_clock: conversion_clock, osc_clock: osc_clock,
                         data: data_in};

   sync2 #(
      .WIDTH    ($bits(pins_s))
   ) pin_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .async_in (pins_async),
      .sync_out (pins)
   );

   // Results are corrected one cycle before they reach the FIFO.
   result_format fmt (
      .clock      (clock),
      .reset_n    (reset_n),
      .raw_valid  (raw_ok && !st_r.cfg.cal),
      .raw_value  (sample_raw),
      .offset_err (st_r.offset),
      .coding_bin (st_r.cfg.coding),
      .result     (result)
   );

   // Strobe decode.
   always_comb begin
      cs_act = !pins.cs0_n && pins.cs1;
      if (st_r.cfg.rw_comb) begin
         rd_act = cs_act && pins.wr_n;                               // [RQ13]
         wr_act = cs_act && !pins.wr_n;                              // [RQ13]
      end else begin
         rd_act = cs_act && !pins.rd_n && pins.wr_n;                 // [RQ14]
         wr_act = cs_act && !pins.wr_n && pins.rd_n;                 // [RQ14]
      end
   end

   assign rd_start  = rd_act && !st_r.prev_rd;
   // Data is taken at the end of the strobe so that it has settled through the synchroniser.
   assign wr_end    = !wr_act && st_r.prev_wr;
   assign tclk_sel  = single_conv_mode ? pins.osc_clock : pins.conversion_clock;
   assign cclk_rise = pins.conversion_clock && !st_r.prev_cclk;
   assign raw_ok    = sample_valid && (st_r.settle == 3'h0);         // [RQ2]
   assign thr_count = threshold_count(st_r.cfg.thr, scan_channels);

   always_comb begin
      st_nxt           = st_r;
      st_nxt.prev_rd   = rd_act;
      st_nxt.prev_wr   = wr_act;
      st_nxt.prev_tclk = tclk_sel;
      st_nxt.prev_cclk = pins.conversion_clock;
      st_nxt.soft_rst  = 1'b0;
      st_nxt.reg0_wr   = 1'b0;
      st_nxt.doe       = rd_act;
      push             = 1'b0;
      pop              = 1'b0;

      if (cclk_rise && st_r.settle != 3'h0) begin
         st_nxt.settle = st_r.settle - 3'h1;                         // [RQ2]
      end

      // Offset calibration: the zeroed-input conversion becomes the stored error.
      if (raw_ok && st_r.cfg.cal) begin
         st_nxt.offset      = sample_raw ^ `MIDSCALE;                // [RQ16]
         st_nxt.cfg.cal     = 1'b0;
      end

      // Host read.
      if (rd_start) begin
         if (st_r.cfg.echo) begin
            st_nxt.echo_second = !st_r.echo_second;                  // [RQ18]
            if (!st_r.echo_second) begin
               st_nxt.dout = {2'b00, ctrl0_value};                   // [RQ18]
            end else begin
               st_nxt.dout = {2'b00, st_r.cfg, st_r.ovf, 1'b0};      // [RQ3]
               st_nxt.ovf  = 1'b0;                                   // [RQ4]
            end
         end else begin
            st_nxt.dout = st_r.mem[st_r.rptr];
            pop         = (st_r.count != '0);
         end
         if (st_r.reads_left != '0) begin
            st_nxt.reads_left = st_r.reads_left - 5'h01;
            st_nxt.armed      = (st_r.reads_left == 5'h01);          // [RQ20]
         end
         if (!st_r.cfg.pulse) begin
            st_nxt.active = 1'b0;                                    // [RQ20]
         end
      end

      // Pulse ends at the next edge of the selected timing clock, half its period.
      if (st_r.cfg.pulse && st_r.active && tclk_sel != st_r.prev_tclk) begin
         st_nxt.active = 1'b0;                                       // [RQ21]
      end

      // FIFO push and pop; a push into a full FIFO with no pop in the same cycle is dropped and flagged.
      if (result.valid) begin
         if (st_r.count == 5'(`FIFO_DEPTH) && !pop) begin
            st_nxt.ovf = 1'b1;                                       // [RQ3]
         end else begin
            push = 1'b1;
         end
      end
      if (push) begin
         st_nxt.mem[st_r.wptr] = result.value;
         st_nxt.wptr           = st_r.wptr + 4'h1;
      end
      if (pop) begin
         st_nxt.rptr = st_r.rptr + 4'h1;
      end
      st_nxt.count = st_r.count + {4'h0, push} - {4'h0, pop};

      // Threshold reached while armed: signal one batch.
      if (st_r.armed && st_nxt.count >= thr_count) begin
         st_nxt.active     = 1'b1;                                   // [RQ6]
         st_nxt.armed      = 1'b0;                                   // [RQ21]
         st_nxt.reads_left = thr_count;
      end

      // Host write.
      if (wr_end) begin
         if (!pins.data[`REG_SEL_BIT]) begin
            st_nxt.reg0_wr   = 1'b1;
            st_nxt.reg0_data = pins.data[`CR_W-1:0];
         end else if (pins.data[`CR1_RESET_BIT]) begin
            // Reset takes priority over every other bit of the same word.
            st_nxt             = '0;                                 // [RQ22]
            st_nxt.cfg         = `CR1_CFG_RESET;                     // [RQ1]
            st_nxt.armed       = 1'b1;
            st_nxt.settle      = `SETTLE_CYCLES;                     // [RQ2]
            st_nxt.soft_rst    = 1'b1;                               // [RQ1]
            st_nxt.prev_rd     = rd_act;
            st_nxt.prev_tclk   = tclk_sel;
            st_nxt.prev_cclk   = pins.conversion_clock;
         end else begin
            st_nxt.cfg.thr     = pins.data[`CR1_THR_HI_BIT:`CR1_THR_LO_BIT];  // [RQ6]
            st_nxt.cfg.pulse   = pins.data[`CR1_PULSE_BIT];          // [RQ11]
            st_nxt.cfg.pol     = pins.data[`CR1_POL_BIT];            // [RQ12]
            st_nxt.cfg.rw_comb = pins.data[`CR1_RW_BIT];             // [RQ13]
            st_nxt.cfg.coding  = pins.data[`CR1_CODING_BIT];         // [RQ15]
            st_nxt.cfg.echo    = pins.data[`CR1_ECHO_BIT];           // [RQ18]
            if (pins.data[`CR1_CAL_BIT]) begin
               st_nxt.cfg.cal = 1'b1;                                // [RQ16]
            end
            if (pins.data[`CR1_ECHO_BIT] && !st_r.cfg.echo) begin
               st_nxt.echo_second = 1'b0;
            end
            if (pins.data[`CR1_FIFO_BIT]) begin
               // A clear never sets the overflow flag; a lost push still does.
               st_nxt.wptr       = '0;                               // [RQ5]
               st_nxt.rptr       = '0;                               // [RQ5]
               st_nxt.count      = '0;                               // [RQ5]
               st_nxt.armed      = 1'b1;
               st_nxt.active     = 1'b0;
               st_nxt.reads_left = '0;
            end
         end
      end

      st_nxt.rdy_out = st_nxt.cfg.pol ? st_nxt.active : !st_nxt.active;  // [RQ12]
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r         <= '0;
         st_r.cfg     <= `CR1_CFG_RESET;
         st_r.armed   <= 1'b1;
         st_r.rdy_out <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign data_out          = st_r.dout;
   assign data_oe           = st_r.doe;
   assign samples_ready_out = st_r.rdy_out;
   assign force_zero_inputs = st_r.cfg.cal;                          // [RQ16]
   assign ctrl0_write       = st_r.reg0_wr;
   assign ctrl0_data        = st_r.reg0_data;
   assign soft_reset_out    = st_r.soft_rst;

endmodule
`default_nettype wire

// ### sim/adc_fifo_control_register_properties.sv
// Port-level checks on the second control register block.
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_checker (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        reset_n,
   // Host pins.
   input  wire logic        cs0_n,
   input  wire logic        cs1,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [10:0] data_in,
   input  wire logic [11:0] data_out,
   input  wire logic        data_oe,
   // Core side.
   input  wire logic        sample_valid,
   input  wire logic        force_zero_inputs,
   input  wire logic        soft_reset_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Pins cross two stages and a register, so three samples settle the enable.
   sequence unselected;
      (cs0_n || !cs1) [*3];
   endsequence
   sequence write_dir;
      (!wr_n) [*3];
   endsequence
   a_idle_no_drive: assert property (unselected |=> !data_oe)
      else $error("data_oe high without chip select");
   a_write_no_drive: assert property (write_dir |=> !data_oe)
      else $error("data_oe high in write direction");
   a_drive_on_read: assert property (
      $rose(data_oe) |-> $past(!cs0_n && cs1 && wr_n, 3))
      else $error("data_oe rose without a read");
   a_drive_release: assert property (
      $fell(data_oe) |-> $past(cs0_n || !cs1 || !wr_n || rd_n, 3))
      else $error("data_oe fell with read still active");
   a_reset_one_cycle: assert property ($rose(soft_reset_out) |=> !soft_reset_out)
      else $error("soft reset pulse too long");
   a_reset_cause: assert property (
      $rose(soft_reset_out) |-> $past(data_in[10] && data_in[0], 3))
      else $error("soft reset without a reset write");
   a_cal_start: assert property (
      $rose(force_zero_inputs) |-> $past(data_in[10] && data_in[8], 3))
      else $error("inputs forced without a calibration write");
   a_cal_release: assert property (
      $fell(force_zero_inputs) |-> $past(sample_valid) || $past(sample_valid, 2)
         || soft_reset_out || $past(soft_reset_out))
      else $error("calibration ended without a conversion");
   a_word_held: assert property (
      !$stable(data_out) |-> $rose(data_oe) || soft_reset_out || $past(soft_reset_out))
      else $error("read word changed outside a read");
endmodule
bind adc_fifo_control_register adc_ctrl_checker chk_i (
   .clock(clock), .reset_n(reset_n), .cs0_n(cs0_n), .cs1(cs1), .rd_n(rd_n),
   .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
   .sample_valid(sample_valid), .force_zero_inputs(force_zero_inputs),
   .soft_reset_out(soft_reset_out));
`default_nettype wire

// ### sim/host_model.sv
// Host processor model driving the chip-select and strobe pins.
`timescale 1ns/1ns
`default_nettype none
module host_model (
   // Clock.
   input  wire logic        clock,
   // Pins to the device.
   output logic             cs0_n,
   output logic             cs1,
   output logic             rd_n,
   output logic             wr_n,
   output logic      [10:0] data_in,
   // Read data.
   input  wire logic [11:0] data_out
);
   initial begin
      cs0_n = 1'b1;
      cs1 = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      data_in = 11'h000;
   end
   // Five clocks low and high keep clear of the three the synchronisers need.
   task automatic access(input logic wr, input logic comb, input logic [10:0] d,
                         output logic [11:0] q);
      @(posedge clock);
      #1;
      data_in = d;
      cs1 = 1'b1;
      if (comb) begin
         wr_n = !wr;
      end
      @(posedge clock);
      #1;
      cs0_n = 1'b0;
      if (!comb) begin
         rd_n = wr;
         wr_n = !wr;
      end
      repeat (5) @(posedge clock);
      q = data_out;
      #1;
      cs0_n = 1'b1;
      cs1 = 1'b0;
      if (!comb) begin
         wr_n = 1'b1;
      end
      // Data and direction outlast the strobe so the synchronised copy is clean.
      repeat (5) @(posedge clock);
      #1;
      wr_n = 1'b1;
      data_in = ~d;
   endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the second control register block.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        cs0_n, cs1, rd_n, wr_n, data_oe, samples_ready_out;
   logic        conversion_clock = 1'b0;
   logic        osc_clock = 1'b0;
   logic        single_conv_mode = 1'b0;
   logic        sample_valid = 1'b0;
   logic        force_zero_inputs, ctrl0_write, soft_reset_out;
   logic [1:0]  scan_channels = 2'h0;
   logic [10:0] data_in;
   logic [11:0] data_out, q, w;
   logic [11:0] sample_raw = 12'h000;
   logic [9:0]  ctrl0_data;
   logic [9:0]  ctrl0_value = 10'h2a5;
   int          err_count = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          n;
   int          resets = 0;
   int          writes0 = 0;
   int          thr_tab [4][4] = '{'{1, 4, 8, 14}, '{2, 4, 8, 12}, '{3, 6, 9, 12}, '{4, 8, 12, 12}};
   always #5 clock = ~clock;
   adc_fifo_control_register dut (.clock, .reset_n, .cs0_n, .cs1, .rd_n, .wr_n, .data_in,
      .data_out, .data_oe, .samples_ready_out, .conversion_clock, .osc_clock,
      .single_conv_mode, .scan_channels, .sample_valid, .sample_raw, .force_zero_inputs,
      .ctrl0_value, .ctrl0_write, .ctrl0_data, .soft_reset_out);
   host_model host (.clock, .cs0_n, .cs1, .rd_n, .wr_n, .data_in, .data_out);
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ticks(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic push(input logic [11:0] raw);
      ticks(1);
      sample_valid = 1'b1;
      sample_raw = raw;
      ticks(1);
      sample_valid = 1'b0;
      sample_raw = ~raw;
      ticks(4);
   endtask
   task automatic wr(input logic comb, input logic [10:0] d);
      host.access(1'b1, comb, d, q);
   endtask
   task automatic rdchk(input logic comb, input logic [11:0] exp);
      host.access(1'b0, comb, 11'h000, q);
      chk(q, exp);
   endtask
   // The conversion clock stands still except while a test needs its edges.
   task automatic cedge(input int k);
      repeat (k) begin
         ticks(4);
         conversion_clock = 1'b1;
         ticks(4);
         conversion_clock = 1'b0;
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      // Both strobes are one-cycle pulses, so they are counted rather than compared.
      if (soft_reset_out === 1'b1) begin
         resets++;
      end
      if (ctrl0_write === 1'b1) begin
         writes0++;
      end
      if (cycles == 30000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      ticks(2);
      reset_n = 1'b1;
      ticks(2);
      chk(samples_ready_out, 1'b0);
      wr(0, 11'h632);
      rdchk(0, {2'h0, ctrl0_value});
      rdchk(0, 12'h230);
      wr(0, 11'h155);
      chk({2'h0, ctrl0_data}, 12'h155);
      chk(12'(writes0), 12'h001);
      // Reset beside low polarity and combined strobes: later separate accesses rely on it.
      wr(0, 11'h4c1);
      chk(samples_ready_out, 1'b0);
      cedge(5);
      for (int ch = 0; ch < 4; ch++) begin
         for (int c = 0; c < 4; c++) begin
            if (ch == 3 && c == 3) continue;
            n = thr_tab[ch][c];
            scan_channels = ch[1:0];
            wr(0, 11'h422 | 11'(c << 2) | 11'((c & 1) << 7));
            for (int i = 0; i < n - 1; i++) begin
               push(12'h100 + 12'(i));
            end
            chk(samples_ready_out, 1'b0);
            push(12'h1ff);
            chk(samples_ready_out, 1'b1);
            w = (n == 1) ? 12'h1ff : 12'h100;
            rdchk(0, c[0] ? w : w ^ 12'h800);
            chk(samples_ready_out, 1'b0);
         end
      end
      scan_channels = 2'h0;
      wr(0, 11'h422);
      for (int i = 0; i < 17; i++) begin
         push(12'h300);
      end
      wr(0, 11'h620);
      for (int k = 0; k < 2; k++) begin
         rdchk(0, {2'h0, ctrl0_value});
         rdchk(0, k ? 12'h220 : 12'h222);
      end
      wr(0, 11'h401);
      cedge(4);
      push(12'h123);
      chk(samples_ready_out, 1'b0);
      cedge(1);
      push(12'h123);
      chk(samples_ready_out, 1'b1);
      cedge(1);
      chk(samples_ready_out, 1'b0);
      push(12'h124);
      chk(samples_ready_out, 1'b0);
      rdchk(0, 12'h923);
      ticks(4);
      chk(samples_ready_out, 1'b1);
      wr(0, 11'h5a2);
      chk(force_zero_inputs, 1'b1);
      push(12'h810);
      chk(force_zero_inputs, 1'b0);
      chk(samples_ready_out, 1'b0);
      push(12'h900);
      chk(samples_ready_out, 1'b1);
      rdchk(0, 12'h8f0);
      wr(0, 11'h401);
      cedge(5);
      push(12'h900);
      rdchk(0, 12'h100);
      wr(0, 11'h462);
      push(12'h456);
      rdchk(1, 12'hc56);
      wr(1, 11'h401);
      cedge(5);
      single_conv_mode = 1'b1;
      wr(0, 11'h412);
      chk(samples_ready_out, 1'b1);
      push(12'h200);
      chk(samples_ready_out, 1'b0);
      osc_clock = 1'b1;
      ticks(5);
      chk(samples_ready_out, 1'b1);
      chk(12'(resets), 12'h004);
      give_verdict();
   end
endmodule
`default_nettype wire
